/* File: core/ppsin_pkg.sv */
// constants, register map and routing table for the peripheral input pin select block
//
// Behaviour
// - each selector field is six bits, software read/write, all ones at reset
// - a selector value n routes remappable pin n to its peripheral input
// - unimplemented selector bits ignore writes and read zero
// - uart3 receive selector sits in bits 13-8, bits 7-0 read zero
// - uart1 cts selector in bits 13-8, uart1 receive selector in bits 5-0
// - uart2 cts selector in bits 13-8, uart2 receive selector in bits 5-0
// - spi clock input selector in bits 13-8, spi data input in 5-0
// - uart3 cts selector in bits 13-8, spi1 slave select in 5-0
// - timer1 external clock selector in 13-8, spi2 data input in 5-0
// - spi2 slave select in bits 5-0, spare six-bit field in 13-8
// - uart4 cts selector in bits 13-8, uart4 receive selector in 5-0
// - modulator transmit input selector in bits 5-0, bits 15-6 read zero
`default_nettype none

package ppsin_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int SEL_W      = 6;
  localparam int REG_W      = 16;
  localparam int NUM_REGS   = 9;
  localparam int NUM_ROUTES = 15;
  localparam int HI_LSB     = 8;
  localparam int LO_LSB     = 0;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_UART3_RX_INPUT_SELECT               = 8'h00;
  localparam logic [7:0] OFF_UART1_INPUT_SELECT                  = 8'h04;
  localparam logic [7:0] OFF_UART2_INPUT_SELECT                  = 8'h08;
  localparam logic [7:0] OFF_SPI_CLOCK_DATA_INPUT_SELECT         = 8'h0c;
  localparam logic [7:0] OFF_UART3_CTS_SPI1_SS_INPUT_SELECT      = 8'h10;
  localparam logic [7:0] OFF_TIMER1_CLOCK_SPI2_DATA_INPUT_SELECT = 8'h14;
  localparam logic [7:0] OFF_SPI2_SLAVE_SELECT_INPUT_SELECT      = 8'h18;
  localparam logic [7:0] OFF_UART4_INPUT_SELECT                  = 8'h1c;
  localparam logic [7:0] OFF_MODULATOR_INPUT_SELECT              = 8'h20;

  localparam logic [7:0] REG_OFFSET [NUM_REGS] = '{
    OFF_UART3_RX_INPUT_SELECT, OFF_UART1_INPUT_SELECT, OFF_UART2_INPUT_SELECT,
    OFF_SPI_CLOCK_DATA_INPUT_SELECT, OFF_UART3_CTS_SPI1_SS_INPUT_SELECT,
    OFF_TIMER1_CLOCK_SPI2_DATA_INPUT_SELECT, OFF_SPI2_SLAVE_SELECT_INPUT_SELECT,
    OFF_UART4_INPUT_SELECT, OFF_MODULATOR_INPUT_SELECT};

  // ----------------------------------------------------------------
  // implemented bits; a register resets to its own mask (all fields ones)
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] MASK_TWO_FIELDS = 16'h3f3f;
  localparam logic [REG_W-1:0] MASK_HI_FIELD   = 16'h3f00;
  localparam logic [REG_W-1:0] MASK_LO_FIELD   = 16'h003f;

  localparam logic [REG_W-1:0] REG_MASK [NUM_REGS] = '{
    MASK_HI_FIELD, MASK_TWO_FIELDS, MASK_TWO_FIELDS, MASK_TWO_FIELDS,
    MASK_TWO_FIELDS, MASK_TWO_FIELDS, MASK_TWO_FIELDS, MASK_TWO_FIELDS,
    MASK_LO_FIELD};

  // ----------------------------------------------------------------
  // routing table, route k drives bit k of the routed vector
  // ----------------------------------------------------------------
  localparam logic [3:0] ROUTE_REG [NUM_ROUTES] = '{
    4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h3, 4'h4,
    4'h4, 4'h5, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8};
  localparam logic [NUM_ROUTES-1:0] ROUTE_HI   = 15'h12ab;
  // idle: receive, cts and slave select high; clocks, data, modulator low
  localparam logic [NUM_ROUTES-1:0] ROUTE_IDLE = 15'h399f;

  // ----------------------------------------------------------------
  // bus answers
  // ----------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic modulator_tx_input;
    logic uart4_rx;
    logic uart4_cts;
    logic spi2_slave_select_input;
    logic spi2_data_in;
    logic timer1_ext_clock_input;
    logic spi1_slave_select_input;
    logic uart3_cts;
    logic spi_data_in;
    logic spi_clock_in;
    logic uart2_rx;
    logic uart2_cts;
    logic uart1_rx;
    logic uart1_cts;
    logic uart3_rx;
  } ppsin_routed_t;

endpackage

`default_nettype wire

/* File: core/ppsin_pin_sync.sv */
// three-stage synchroniser with agreement filter for the remappable pins
`default_nettype none

module ppsin_pin_sync #(
  parameter int WIDTH = 48
) (
  input  wire logic             aclk,
  input  wire logic             aresetn,
  input  wire logic [WIDTH-1:0] pin_in,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] next_pin_sync;

  // a bit moves only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < WIDTH; i++)
    begin
      next_pin_sync[i] = (stage2[i] == stage3[i]) ? stage3[i] : pin_sync[i];
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stage1   <= '0;
      stage2   <= '0;
      stage3   <= '0;
      pin_sync <= '0;
    end
    else
    begin
      stage1   <= pin_in;
      stage2   <= stage1;
      stage3   <= stage2;
      pin_sync <= next_pin_sync;
    end
  end

endmodule

`default_nettype wire

/* File: core/ppsin_route_mux.sv */
// one routed peripheral input: picks a synchronised pin by selector, registered
`default_nettype none

module ppsin_route_mux #(
  parameter int   NUM_PINS = 48,
  parameter logic IDLE     = 1'b1
) (
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  input  wire logic [NUM_PINS-1:0]         pins,
  input  wire logic [ppsin_pkg::SEL_W-1:0] sel,
  output logic                             routed
);

  localparam logic [ppsin_pkg::SEL_W-1:0] SEL_NONE = '1;

  logic next_routed;

  always_comb
  begin
    // all ones and any number past the last pin leave the input idle
    if ((sel != SEL_NONE) && (int'(sel) < NUM_PINS))
    begin
      next_routed = pins[sel];
    end
    else
    begin
      next_routed = IDLE;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      routed <= IDLE;
    end
    else
    begin
      routed <= next_routed;
    end
  end

endmodule

`default_nettype wire

/* File: core/ppsin_input_select.sv */
// peripheral input pin select: selector registers on axi4-lite and input routing
`default_nettype none

module ppsin_input_select #(
  parameter int NUM_PINS = 48,
  parameter int ADDR_W   = 8
) (
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  input  wire logic [ADDR_W-1:0]        s_axi_awaddr,
  input  wire logic [2:0]               s_axi_awprot,
  input  wire logic                     s_axi_awvalid,
  output logic                          s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output logic                          s_axi_wready,
  output logic [1:0]                    s_axi_bresp,
  output logic                          s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  input  wire logic [ADDR_W-1:0]        s_axi_araddr,
  input  wire logic [2:0]               s_axi_arprot,
  input  wire logic                     s_axi_arvalid,
  output logic                          s_axi_arready,
  output logic [31:0]                   s_axi_rdata,
  output logic [1:0]                    s_axi_rresp,
  output logic                          s_axi_rvalid,
  input  wire logic                     s_axi_rready,
  input  wire logic [NUM_PINS-1:0]      remappable_io_pin,
  output ppsin_pkg::ppsin_routed_t      routed
);

  localparam int NR = ppsin_pkg::NUM_REGS;
  localparam int NT = ppsin_pkg::NUM_ROUTES;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // returns the register index, or NR when nothing answers there
  function automatic logic [3:0] decode(input logic [ADDR_W-1:0] addr);
    logic [3:0] idx;
    idx = 4'(NR);
    for (int i = 0; i < NR; i++)
    begin
      if (addr == ADDR_W'(ppsin_pkg::REG_OFFSET[i]))
      begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // ----------------------------------------------------------------
  // write channel state
  // ----------------------------------------------------------------
  logic                         aw_held;
  logic [ADDR_W-1:0]            aw_addr;
  logic                         w_held;
  logic [31:0]                  w_data;
  logic [3:0]                   w_strb;
  logic                         bvalid;
  logic [1:0]                   bresp;
  logic                         next_aw_held;
  logic [ADDR_W-1:0]            next_aw_addr;
  logic                         next_w_held;
  logic [31:0]                  next_w_data;
  logic [3:0]                   next_w_strb;
  logic                         next_bvalid;
  logic [1:0]                   next_bresp;
  logic                         wr_fire;
  logic [3:0]                   wr_idx;

  // ----------------------------------------------------------------
  // read channel state
  // ----------------------------------------------------------------
  logic                         rvalid;
  logic [31:0]                  rdata;
  logic [1:0]                   rresp;
  logic                         next_rvalid;
  logic [31:0]                  next_rdata;
  logic [1:0]                   next_rresp;
  logic [3:0]                   rd_idx;

  // ----------------------------------------------------------------
  // selector registers
  // ----------------------------------------------------------------
  logic [ppsin_pkg::REG_W-1:0]  sel_reg      [NR];
  logic [ppsin_pkg::REG_W-1:0]  next_sel_reg [NR];
  logic [ppsin_pkg::REG_W-1:0]  lane_mask;

  assign s_axi_awready = !aw_held;
  assign s_axi_wready  = !w_held;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // address and data are taken in either order; the write happens once both are held and no write answer is pending
  assign wr_fire   = aw_held && w_held && !bvalid;
  assign wr_idx    = decode(aw_addr);
  assign rd_idx    = decode(s_axi_araddr);
  assign lane_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    for (int i = 0; i < NR; i++)
    begin
      next_sel_reg[i] = sel_reg[i];
    end
    if (s_axi_awvalid && !aw_held)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready)
    begin
      next_bvalid = 1'b0;
    end
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = ppsin_pkg::RESP_SLVERR;
      for (int i = 0; i < NR; i++)
      begin
        if (wr_idx == 4'(i))
        begin
          // only implemented field bits take the data; byte lanes 2 and 3 hold nothing
          next_sel_reg[i] = ((sel_reg[i] & ~lane_mask)
                            | (w_data[ppsin_pkg::REG_W-1:0] & lane_mask))
                            & ppsin_pkg::REG_MASK[i];
          next_bresp      = ppsin_pkg::RESP_OKAY;
        end
      end
    end
  end

  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rvalid && s_axi_rready)
    begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid)
    begin
      next_rvalid = 1'b1;
      next_rdata  = 32'h0000_0000;
      next_rresp  = ppsin_pkg::RESP_SLVERR;
      for (int i = 0; i < NR; i++)
      begin
        if (rd_idx == 4'(i))
        begin
          // unimplemented bits and the upper half read zero
          next_rdata = {16'h0000, sel_reg[i] & ppsin_pkg::REG_MASK[i]};
          next_rresp = ppsin_pkg::RESP_OKAY;
        end
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= ppsin_pkg::RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= ppsin_pkg::RESP_OKAY;
      for (int i = 0; i < NR; i++)
      begin
        sel_reg[i] <= ppsin_pkg::REG_MASK[i];
      end
    end
    else
    begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      for (int i = 0; i < NR; i++)
      begin
        sel_reg[i] <= next_sel_reg[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // pin synchronisation and routing
  // ----------------------------------------------------------------
  logic [NUM_PINS-1:0] pins_sync;
  logic [NT-1:0]       routed_vec;

  ppsin_pin_sync #(
    .WIDTH    (NUM_PINS)
  ) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .pin_in   (remappable_io_pin),
    .pin_sync (pins_sync)
  );

  // the spare high field of the spi2 slave select register is stored but steers nothing
  for (genvar k = 0; k < NT; k++)
  begin : g_route
    logic [ppsin_pkg::SEL_W-1:0] sel;
    // hi fields sit in 13-8, lo fields in 5-0 of the route's register
    assign sel = ppsin_pkg::ROUTE_HI[k]
               ? sel_reg[ppsin_pkg::ROUTE_REG[k]][ppsin_pkg::HI_LSB +: ppsin_pkg::SEL_W]
               : sel_reg[ppsin_pkg::ROUTE_REG[k]][ppsin_pkg::LO_LSB +: ppsin_pkg::SEL_W];
    // registered mux: a new selector shows one cycle after the register takes it
    ppsin_route_mux #(
      .NUM_PINS (NUM_PINS),
      .IDLE     (ppsin_pkg::ROUTE_IDLE[k])
    ) u_mux (
      .aclk     (aclk),
      .aresetn  (aresetn),
      .pins     (pins_sync),
      .sel      (sel),
      .routed   (routed_vec[k])
    );
  end

  assign routed = ppsin_pkg::ppsin_routed_t'(routed_vec);

endmodule

`default_nettype wire

/* File: sim/ppsin_input_select_checker.sv */
// assertions on the bus answers and routed levels of the input pin select block
`default_nettype none
module ppsin_input_select_checker #(
  parameter int NUM_PINS = 48
) (
  input wire logic                     aclk,
  input wire logic                     aresetn,
  input wire logic                     s_axi_awvalid,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wvalid,
  input wire logic                     s_axi_wready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arvalid,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic [1:0]               s_axi_rresp,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire ppsin_pkg::ppsin_routed_t routed
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ------------------------------------------------------------
  // bus steps
  // ------------------------------------------------------------
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  chk_write_answer: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  chk_read_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer late");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  chk_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read lanes not zero");
  chk_unimpl_zero: assert property (s_axi_rvalid |-> s_axi_rdata[15:14] == 2'b00
    && s_axi_rdata[7:6] == 2'b00) else $error("unimplemented bits not zero");
  chk_reset_idle: assert property ($rose(aresetn) |-> routed == ppsin_pkg::ROUTE_IDLE)
    else $error("routed not idle after reset");
  chk_err_data: assert property (s_axi_rvalid && s_axi_rresp == ppsin_pkg::RESP_SLVERR
    |-> s_axi_rdata == 32'h0000_0000) else $error("refused read carries data");
endmodule

bind ppsin_input_select ppsin_input_select_checker #(.NUM_PINS(NUM_PINS)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .routed(routed));
`default_nettype wire

/* File: sim/peripheral_input_pin_select_bench.sv */
// self-checking bench for the input pin select block
`default_nettype none
module peripheral_input_pin_select_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic                     aclk = 1'b0;
  logic                     aresetn = 1'b0;
  logic [7:0]               awaddr = 8'h00, araddr = 8'h00;
  logic [31:0]              wdata = 32'h0000_0000, rdata;
  logic [3:0]               wstrb = 4'h0;
  logic [1:0]               bresp, rresp;
  logic                     awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic                     arvalid = 1'b0, rready = 1'b0;
  logic                     awready, wready, bvalid, arready, rvalid;
  logic [47:0]              pins = 48'h0000_0000_0000;
  ppsin_pkg::ppsin_routed_t routed;
  logic [15:0]              shadow [9];
  logic [31:0]              seed = 32'hafd9_2d01;
  int                       fails = 0;
  int                       n_tests = 0;

  always #5 aclk = ~aclk;

  ppsin_input_select #(.NUM_PINS(48), .ADDR_W(8)) u_ppsin_input_select (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .remappable_io_pin(pins),
    .routed(routed));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0000_0000);
    return seed;
  endfunction

  // selector 48..63 names no pin, so the route rests at its idle level
  function automatic ppsin_pkg::ppsin_routed_t exp_routed();
    logic [15:0] r;
    logic [5:0]  s;
    exp_routed = ppsin_pkg::ROUTE_IDLE;
    for (int k = 0; k < 15; k++)
    begin
      r = shadow[ppsin_pkg::ROUTE_REG[k]];
      s = ppsin_pkg::ROUTE_HI[k] ? r[13:8] : r[5:0];
      if (s < 6'h30) exp_routed[k] = pins[s];
    end
  endfunction

  task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_resp(input logic [1:0] got, input logic [1:0] exp);
    cmp_word({30'h0, got}, {30'h0, exp});
  endtask

  task automatic cmp_route(input logic [14:0] got, input logic [14:0] exp);
    cmp_word({17'h0, got}, {17'h0, exp});
  endtask

  // ------------------------------------------------------------
  // bus master; answers are taken with random stalls on the ready
  // ------------------------------------------------------------
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] st,
                           output logic [1:0] resp);
    logic [31:0] t;
    bit          aw_ok, w_ok, b_ok;
    t = rnd();
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (int n = 0; 1; n++)
    begin
      @(negedge aclk);
      aw_ok = awvalid && awready;
      w_ok = wvalid && wready;
      b_ok = bvalid && bready;
      resp = bresp;
      @(posedge aclk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
      if (b_ok)
      begin
        bready <= 1'b0;
        break;
      end
      if (n >= t[1:0]) bready <= 1'b1;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic [31:0] t;
    bit          ar_ok, r_ok;
    t = rnd();
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    for (int n = 0; 1; n++)
    begin
      @(negedge aclk);
      ar_ok = arvalid && arready;
      r_ok = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ar_ok) arvalid <= 1'b0;
      if (r_ok)
      begin
        rready <= 1'b0;
        break;
      end
      if (n >= t[1:0]) rready <= 1'b1;
    end
  endtask

  task automatic reset_check();
    logic [31:0] d;
    logic [1:0]  r;
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    cmp_route(routed, ppsin_pkg::ROUTE_IDLE);
    for (int i = 0; i < 9; i++)
    begin
      shadow[i] = ppsin_pkg::REG_MASK[i];
      axi_read(ppsin_pkg::REG_OFFSET[i], d, r);
      cmp_word(d, {16'h0000, ppsin_pkg::REG_MASK[i]});
    end
    $display("test reset done");
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial
  begin
    #200_000;
    fails++;
    close_out();
  end

  initial
  begin
    logic [31:0] d, rd, t;
    logic [15:0] m;
    logic [3:0]  st;
    logic [1:0]  r;
    reset_check();
    axi_write(8'h24, 32'h0000_0000, 4'hf, r);
    cmp_resp(r, ppsin_pkg::RESP_SLVERR);
    axi_read(8'h05, rd, r);
    cmp_resp(r, ppsin_pkg::RESP_SLVERR);
    cmp_word(rd, 32'h0000_0000);
    // a refused write must not alias onto a mapped register with the same low bits
    axi_read(ppsin_pkg::OFF_UART1_INPUT_SELECT, rd, r);
    cmp_word(rd, {16'h0000, ppsin_pkg::MASK_TWO_FIELDS});
    for (int it = 0; it < 20; it++)
    begin
      t = rnd();
      pins <= {t[15:0], rnd()};
      // pins pass the synchroniser before routing is judged
      repeat (8) @(posedge aclk);
      for (int i = 0; i < 9; i++)
      begin
        d = rnd();
        if (it == 0) d = 32'hffff_2f00;
        if (it == 1) d = 32'h0000_3130;
        st = (it < 2) ? 4'hf : d[19:16];
        axi_write(ppsin_pkg::REG_OFFSET[i], d, st, r);
        cmp_resp(r, ppsin_pkg::RESP_OKAY);
        m = {{8{st[1]}}, {8{st[0]}}};
        shadow[i] = ((shadow[i] & ~m) | (d[15:0] & m)) & ppsin_pkg::REG_MASK[i];
        @(negedge aclk);
        cmp_route(routed, exp_routed());
        axi_read(ppsin_pkg::REG_OFFSET[i], rd, r);
        cmp_word(rd, {16'h0000, shadow[i]});
      end
      $display("test route pass %0d done", it);
    end
    reset_check();
    close_out();
  end
endmodule
`default_nettype wire
